// ### rtcob_pkg.sv
// rtcob_pkg: constants, types and state layout of the oscillator and battery switch config block
package rtcob_pkg;

  localparam logic [7:0] RTCOB_OSC_OFS    = 8'h25;
  localparam logic [7:0] RTCOB_BSW_OFS    = 8'h26;
  localparam logic [7:0] RTCOB_FLAGS_OFS  = 8'h2B;
  localparam logic [7:0] RTCOB_OSC_RST    = 8'h00;
  localparam logic [4:0] RTCOB_BSW_RST    = 5'h00;
  localparam logic [6:0] RTCOB_DEV_ADDR   = 7'h50; // arbitrary bus address
  localparam logic [3:0] RTCOB_BYTE_BITS  = 4'h8;

  localparam int RTCOB_CLKINV_BIT = 7;
  localparam int RTCOB_OFSMOD_BIT = 6;
  localparam int RTCOB_H12_BIT   = 5;
  localparam int RTCOB_LOWJIT_BIT = 4;
  localparam int RTCOB_DRV_MSB   = 3;
  localparam int RTCOB_DRV_LSB   = 2;
  localparam int RTCOB_CAP_MSB   = 1;
  localparam int RTCOB_CAP_LSB   = 0;
  localparam int RTCOB_SWOFF_BIT  = 4;
  localparam int RTCOB_REFR_BIT   = 3;
  localparam int RTCOB_CMP_MSB    = 2;
  localparam int RTCOB_CMP_LSB    = 1;
  localparam int RTCOB_THR_BIT    = 0;
  localparam int RTCOB_BATFLG_BIT = 0;

  typedef enum logic [1:0] {
    RTCOB_DRV_NORMAL = 2'b00,
    RTCOB_DRV_LOW    = 2'b01,
    RTCOB_DRV_HIGH   = 2'b10
  } rtcob_drive_e;

  typedef enum logic [1:0] {
    RTCOB_CAP_7P0  = 2'b00,
    RTCOB_CAP_6P0  = 2'b01,
    RTCOB_CAP_12P5 = 2'b10
  } rtcob_cap_e;

  typedef enum logic [2:0] {
    RTCOB_IDLE = 3'b000,
    RTCOB_ADDR = 3'b001,
    RTCOB_REG  = 3'b010,
    RTCOB_WDAT = 3'b011,
    RTCOB_ACK  = 3'b100,
    RTCOB_RDAT = 3'b101,
    RTCOB_RACK = 3'b110
  } rtcob_bus_e;

  typedef struct packed {
    logic         clk_invert;
    logic         offset_mode;
    logic         hour_12;
    logic         low_jitter;
    rtcob_drive_e drive;
    rtcob_cap_e   load_cap;
    logic         switchover_disable;
    logic         refresh_rate;
    logic [1:0]   compare_sel;
    logic         threshold_sel;
  } rtcob_cfg_s;

  typedef struct packed {
    rtcob_bus_e st;
    rtcob_bus_e after_ack;
    logic [3:0] bits;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic       rw;
    logic       nack;
    logic       sda_low;
    logic       scl_p;
    logic       sda_p;
    logic [7:0] osc;
    logic [4:0] bsw;
    logic       bat_flag;
    logic       bat_p;
    logic       pulse;
    logic       tick_seen;
    logic       clk_out;
    logic       clk_hiz;
    logic       irq_low;
    logic       stamp_drive;
    logic       stamp_val;
    logic       stamp_din;
    logic       stamp_mech;
  } rtcob_state_s;

endpackage : rtcob_pkg

// ### rtcob_cfg.sv
// rtcob_cfg: two-wire register slave, oscillator and battery switch-over control
//
// Behaviour
// - bit 7 inverts the selected clock output
// - bit 5 selects 12-hour, else 24-hour counting
// - hour format ignored in stop-watch mode
// - bit 4 enables low-jitter clock output
// - drive: 00 normal, 01 low, 1x high
// - load cap: 00 7.0, 01 6.0, 1x 12.5
// - flag set on each change to battery
// - flag readable only on main supply
// - interrupt on battery entry and exit
// - serial bus pins ignored on battery
// - clock output pin high impedance on battery
// - timestamp output off, input ignored on battery
// - mechanical switch detector stays active on battery
// - interrupt pin active on battery, clock off
// - switch-over disable bit turns circuit off
// - flag stays set until software clears
// - pulse cleared by 128 Hz, 1-2 periods
`timescale 1ns/10ps
module rtcob_cfg
  import rtcob_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = RTCOB_DEV_ADDR
)
(
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_B_O,
  input  wire logic       BATTERY_MODE_I,
  input  wire logic       STOPWATCH_MODE_I,
  input  wire logic       CLK_SEL_I,
  input  wire logic       TICK_128HZ_I,
  input  wire logic       BS_INT_EN_I,
  input  wire logic       INT_LEVEL_MODE_I,
  input  wire logic       INT_OTHER_I,
  input  wire logic       INT_PIN_BAT_IND_I,
  input  wire logic       INT_PIN_CLK_MODE_I,
  input  wire logic       STAMP_OUT_EN_I,
  input  wire logic       STAMP_OUT_I,
  input  wire logic       STAMP_DIN_I,
  input  wire logic       STAMP_MECH_I,
  output rtcob_cfg_s      CFG_O,
  output logic            BATTERY_SWITCHED_FLAG_O,
  output logic            CLK_OUT_O,
  output logic            CLK_OUT_OE_B_O,
  output logic            INT_PIN_O,
  output logic            INT_PIN_OE_B_O,
  output logic            STAMP_O,
  output logic            STAMP_OE_B_O,
  output logic            STAMP_DIN_O,
  output logic            STAMP_MECH_O
);

  rtcob_state_s s_q;
  rtcob_state_s s_d;

  logic       bat;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       bat_enter;
  logic       bat_leave;
  logic [7:0] rd_data;

  // switch-over only exists while the circuit is enabled
  assign bat        = BATTERY_MODE_I & ~s_q.bsw[RTCOB_SWOFF_BIT];
  // bus pins are forced idle on battery, so floating pins do no harm
  assign scl        = bat | SCL_I;
  assign sda        = bat | SDA_I;
  assign scl_rise   = scl & ~s_q.scl_p;
  assign scl_fall   = ~scl & s_q.scl_p;
  assign start_seen = scl & s_q.scl_p & s_q.sda_p & ~sda;
  assign stop_seen  = scl & s_q.scl_p & ~s_q.sda_p & sda;
  assign bat_enter  = bat & ~s_q.bat_p;
  assign bat_leave  = ~bat & s_q.bat_p;

  always_comb
  begin
    case (s_q.ptr)
      RTCOB_OSC_OFS:   rd_data = s_q.osc;
      RTCOB_BSW_OFS:   rd_data = {3'h0, s_q.bsw};
      RTCOB_FLAGS_OFS: rd_data = {7'h00, s_q.bat_flag};
      default:         rd_data = 8'h00;
    endcase
  end

  always_comb
  begin
    s_d       = s_q;
    s_d.scl_p = scl;
    s_d.sda_p = sda;
    s_d.bat_p = bat;

    if (bat_enter)
    begin
      s_d.bat_flag = 1'b1;
    end

    if (bat || stop_seen)
    begin
      s_d.st      = RTCOB_IDLE;
      s_d.sda_low = 1'b0;
    end
    else if (start_seen)
    begin
      s_d.st      = RTCOB_ADDR;
      s_d.bits    = 4'h0;
      s_d.sda_low = 1'b0;
    end
    else
    begin
      case (s_q.st)
        RTCOB_ADDR, RTCOB_REG, RTCOB_WDAT:
        begin
          if (scl_rise)
          begin
            s_d.shift = {s_q.shift[6:0], sda};
            s_d.bits  = s_q.bits + 4'h1;
          end
          else if (scl_fall && s_q.bits == RTCOB_BYTE_BITS)
          begin
            s_d.st      = RTCOB_ACK;
            s_d.sda_low = 1'b1;
            s_d.bits    = 4'h0;
            if (s_q.st == RTCOB_ADDR)
            begin
              s_d.rw        = s_q.shift[0];
              s_d.after_ack = s_q.shift[0] ? RTCOB_RDAT : RTCOB_REG;
              if (s_q.shift[7:1] != DEV_ADDR)
              begin
                // foreign address: stay off the line until the next start
                s_d.st      = RTCOB_IDLE;
                s_d.sda_low = 1'b0;
              end
            end
            else if (s_q.st == RTCOB_REG)
            begin
              s_d.ptr       = s_q.shift;
              s_d.after_ack = RTCOB_WDAT;
            end
            else
            begin
              s_d.after_ack = RTCOB_WDAT;
              s_d.ptr       = s_q.ptr + 8'h01;
              if (s_q.ptr == RTCOB_OSC_OFS)
              begin
                s_d.osc = s_q.shift;
              end
              if (s_q.ptr == RTCOB_BSW_OFS)
              begin
                s_d.bsw = s_q.shift[4:0];
              end
              // a new switch-over in the same cycle keeps the flag set
              if (s_q.ptr == RTCOB_FLAGS_OFS && !s_q.shift[RTCOB_BATFLG_BIT] && !bat_enter)
              begin
                s_d.bat_flag = 1'b0;
                s_d.pulse = 1'b0;
              end
            end
          end
        end
        RTCOB_ACK, RTCOB_RACK:
        begin
          if (scl_rise)
          begin
            s_d.nack = (s_q.st == RTCOB_RACK) & sda;
          end
          else if (scl_fall)
          begin
            s_d.sda_low = 1'b0;
            s_d.st      = s_q.after_ack;
            if (s_q.st == RTCOB_RACK && s_q.nack)
            begin
              s_d.st = RTCOB_IDLE;
            end
            else if (s_q.after_ack == RTCOB_RDAT)
            begin
              s_d.shift   = rd_data;
              s_d.sda_low = ~rd_data[7];
              s_d.ptr     = s_q.ptr + 8'h01;
              s_d.bits    = 4'h0;
            end
          end
        end
        RTCOB_RDAT:
        begin
          if (scl_rise)
          begin
            s_d.bits = s_q.bits + 4'h1;
          end
          else if (scl_fall)
          begin
            if (s_q.bits == RTCOB_BYTE_BITS)
            begin
              s_d.st        = RTCOB_RACK;
              s_d.after_ack = RTCOB_RDAT;
              s_d.sda_low   = 1'b0;
            end
            else
            begin
              s_d.shift   = {s_q.shift[6:0], 1'b0};
              s_d.sda_low = ~s_q.shift[6];
            end
          end
        end
        RTCOB_IDLE:
        begin
          s_d.sda_low = 1'b0;
        end
        default:
        begin
          s_d.st      = RTCOB_IDLE;
          s_d.sda_low = 1'b0;
        end
      endcase
    end

    // the tick is free running, so a pulse lasts one to two tick periods
    if (bat_enter || bat_leave)
    begin
      s_d.pulse     = 1'b1;
      s_d.tick_seen = 1'b0;
    end
    else if (TICK_128HZ_I && s_q.pulse)
    begin
      s_d.tick_seen = 1'b1;
      s_d.pulse     = ~s_q.tick_seen;
    end

    if (INT_PIN_BAT_IND_I)
    begin
      s_d.irq_low = bat;
    end
    else if (INT_PIN_CLK_MODE_I)
    begin
      s_d.irq_low = ~bat & ~s_q.clk_out;
    end
    else
    begin
      s_d.irq_low = INT_OTHER_I |
                    (BS_INT_EN_I & (INT_LEVEL_MODE_I ? s_d.bat_flag : s_d.pulse));
    end

    s_d.clk_out     = CLK_SEL_I ^ s_q.osc[RTCOB_CLKINV_BIT];
    s_d.clk_hiz     = bat;
    s_d.stamp_drive = STAMP_OUT_EN_I & ~bat;
    s_d.stamp_val   = STAMP_OUT_I;
    s_d.stamp_din   = STAMP_DIN_I & ~bat;
    s_d.stamp_mech  = STAMP_MECH_I;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_B_I)
    begin
      s_q           <= '0;
      s_q.st        <= RTCOB_IDLE;
      s_q.after_ack <= RTCOB_IDLE;
      s_q.scl_p     <= 1'b1;
      s_q.sda_p     <= 1'b1;
      s_q.osc       <= RTCOB_OSC_RST;
      s_q.bsw       <= RTCOB_BSW_RST;
      s_q.clk_hiz   <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    CFG_O.clk_invert         = s_q.osc[RTCOB_CLKINV_BIT];
    CFG_O.offset_mode        = s_q.osc[RTCOB_OFSMOD_BIT];
    CFG_O.hour_12            = s_q.osc[RTCOB_H12_BIT] & ~STOPWATCH_MODE_I;
    CFG_O.low_jitter         = s_q.osc[RTCOB_LOWJIT_BIT];
    CFG_O.drive              = s_q.osc[RTCOB_DRV_MSB] ? RTCOB_DRV_HIGH :
                               rtcob_drive_e'(s_q.osc[RTCOB_DRV_MSB:RTCOB_DRV_LSB]);
    CFG_O.load_cap           = s_q.osc[RTCOB_CAP_MSB] ? RTCOB_CAP_12P5 :
                               rtcob_cap_e'(s_q.osc[RTCOB_CAP_MSB:RTCOB_CAP_LSB]);
    CFG_O.switchover_disable = s_q.bsw[RTCOB_SWOFF_BIT];
    CFG_O.refresh_rate       = s_q.bsw[RTCOB_REFR_BIT];
    CFG_O.compare_sel        = s_q.bsw[RTCOB_CMP_MSB:RTCOB_CMP_LSB];
    CFG_O.threshold_sel      = s_q.bsw[RTCOB_THR_BIT];
  end

  assign BATTERY_SWITCHED_FLAG_O = s_q.bat_flag;
  assign SDA_O                   = 1'b0;
  assign SDA_OE_B_O              = ~s_q.sda_low;
  assign CLK_OUT_O               = s_q.clk_out;
  assign CLK_OUT_OE_B_O          = s_q.clk_hiz;
  assign INT_PIN_O               = 1'b0;
  assign INT_PIN_OE_B_O          = ~s_q.irq_low;
  assign STAMP_O                 = s_q.stamp_val;
  assign STAMP_OE_B_O            = ~s_q.stamp_drive;
  assign STAMP_DIN_O             = s_q.stamp_din;
  assign STAMP_MECH_O            = s_q.stamp_mech;

endmodule : rtcob_cfg

// ### rtcob_cfg_monitor.sv
// rtcob_cfg_monitor: port assertions for the config block
`timescale 1ns/10ps
module rtcob_cfg_mon
  import rtcob_pkg::*;
(
  input wire logic       REF_CLK_I,
  input wire logic       RST_B_I,
  input wire logic       SCL_I,
  input wire logic       BATTERY_MODE_I,
  input wire logic       STOPWATCH_MODE_I,
  input wire logic       CLK_SEL_I,
  input wire logic       BS_INT_EN_I,
  input wire logic       INT_LEVEL_MODE_I,
  input wire logic       INT_PIN_BAT_IND_I,
  input wire logic       INT_PIN_CLK_MODE_I,
  input wire logic       STAMP_MECH_I,
  input wire rtcob_cfg_s CFG_O,
  input wire logic       BATTERY_SWITCHED_FLAG_O,
  input wire logic       CLK_OUT_O,
  input wire logic       CLK_OUT_OE_B_O,
  input wire logic       INT_PIN_OE_B_O,
  input wire logic       STAMP_OE_B_O,
  input wire logic       STAMP_DIN_O,
  input wire logic       STAMP_MECH_O,
  input wire logic       SDA_OE_B_O
);
  wire logic bat_on;
  assign bat_on = BATTERY_MODE_I & ~CFG_O.switchover_disable;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  clk_inv_a: assert property (!bat_on ##1 !bat_on |-> CLK_OUT_O == $past(CLK_SEL_I ^ CFG_O.clk_invert))
    else $error("clock output mismatch");
  hour_sw_a: assert property (STOPWATCH_MODE_I |-> !CFG_O.hour_12)
    else $error("hour format not ignored");
  flag_set_a: assert property ($rose(BATTERY_MODE_I) && !CFG_O.switchover_disable |=> BATTERY_SWITCHED_FLAG_O)
    else $error("flag not set");
  bus_off_a: assert property (bat_on [*2] |-> SDA_OE_B_O)
    else $error("data line driven on battery");
  clk_hiz_a: assert property (bat_on |=> CLK_OUT_OE_B_O)
    else $error("clock pin driven on battery");
  ts_off_a: assert property (bat_on |=> STAMP_OE_B_O && !STAMP_DIN_O)
    else $error("timestamp pin active on battery");
  mech_on_a: assert property (1 |=> STAMP_MECH_O == $past(STAMP_MECH_I))
    else $error("switch detector lost");
  flag_hold_a: assert property (BATTERY_SWITCHED_FLAG_O && SCL_I |=> BATTERY_SWITCHED_FLAG_O)
    else $error("flag dropped");
  pulse_on_a: assert property (BS_INT_EN_I && !INT_LEVEL_MODE_I && !INT_PIN_BAT_IND_I
    && !INT_PIN_CLK_MODE_I && $rose(bat_on) |=> ##1 !INT_PIN_OE_B_O)
    else $error("no interrupt pulse");
  level_on_a: assert property (INT_LEVEL_MODE_I && BS_INT_EN_I && BATTERY_SWITCHED_FLAG_O
    && !INT_PIN_CLK_MODE_I |-> ##[0:1] !INT_PIN_OE_B_O)
    else $error("level interrupt missing");
  cover property (!SDA_OE_B_O);
  cover property ($fell(INT_PIN_OE_B_O));
  cover property ($rose(BATTERY_SWITCHED_FLAG_O));
endmodule : rtcob_cfg_mon

bind rtcob_cfg rtcob_cfg_mon u_mon (.*);

// ### test_rtcob_cfg.sv
// test_rtcob_cfg: register access and battery switch-over tests
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_rtcob_cfg;
  import rtcob_pkg::*;
  logic REF_CLK_I = 0, RST_B_I = 0, SCL_I = 1, sda_m = 1, BATTERY_MODE_I = 0;
  logic STOPWATCH_MODE_I = 0, CLK_SEL_I = 0, TICK_128HZ_I = 0, BS_INT_EN_I = 0;
  logic INT_LEVEL_MODE_I = 0, INT_OTHER_I = 0, INT_PIN_BAT_IND_I = 0, INT_PIN_CLK_MODE_I = 0;
  logic STAMP_OUT_EN_I = 0, STAMP_OUT_I = 0, STAMP_DIN_I = 0, STAMP_MECH_I = 0;
  logic SDA_O, SDA_OE_B_O, BATTERY_SWITCHED_FLAG_O, CLK_OUT_O, CLK_OUT_OE_B_O;
  logic INT_PIN_O, INT_PIN_OE_B_O, STAMP_O, STAMP_OE_B_O, STAMP_DIN_O, STAMP_MECH_O;
  rtcob_cfg_s CFG_O;
  wire logic SDA_I;
  int bad_count = 0, n_checks = 0, cyc = 0;
  logic [7:0] v;
  logic a;
  // open-drain wire: either party can pull low
  assign SDA_I = sda_m & (SDA_OE_B_O | SDA_O);
  rtcob_cfg dut (.*);
  always #25 REF_CLK_I = ~REF_CLK_I;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  always @(posedge REF_CLK_I)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  task automatic cy(input int n);
    repeat (n) @(negedge REF_CLK_I);
  endtask : cy
  task automatic bx(input logic b, output logic r);
    sda_m = b;
    cy(2);
    SCL_I = 1;
    cy(2);
    r = SDA_I;
    SCL_I = 0;
  endtask : bx
  task automatic by(input logic [7:0] d, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
    bx(1'b1, k);
  endtask : by
  task automatic st;
    sda_m = 1;
    cy(1);
    SCL_I = 1;
    cy(2);
    sda_m = 0;
    cy(2);
    SCL_I = 0;
  endtask : st
  task automatic sp;
    sda_m = 0;
    cy(1);
    SCL_I = 1;
    cy(2);
    sda_m = 1;
    cy(2);
  endtask : sp
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic [7:0] q;
    logic [2:0] k;
    st();
    by({RTCOB_DEV_ADDR, 1'b0}, q, k[2]);
    by(r, q, k[1]);
    by(d, q, k[0]);
    sp();
    `CHK("wr ack", 3'b000, k)
  endtask : wr
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic [7:0] q;
    logic [3:0] k;
    st();
    by({RTCOB_DEV_ADDR, 1'b0}, q, k[3]);
    by(r, q, k[2]);
    st();
    by({RTCOB_DEV_ADDR, 1'b1}, q, k[1]);
    by(8'hFF, d, k[0]);
    sp();
    `CHK("rd ack", 4'b0001, k)
  endtask : rd
  task automatic tick2;
    repeat (2)
    begin
      TICK_128HZ_I = 1;
      cy(1);
      TICK_128HZ_I = 0;
      cy(3);
    end
  endtask : tick2
  initial
  begin
    cy(3);
    RST_B_I = 1;
    cy(2);
    `CHK("cfg rst", '0, CFG_O)
    rd(RTCOB_OSC_OFS, v);
    `CHK("osc rst", 8'h00, v)
    rd(8'h30, v);
    `CHK("unmapped", 8'h00, v)
    $display("test reset done");
    // every drive and cap code, bits 7, 5 and 4 set
    for (int i = 0; i < 4; i++)
    begin
      wr(RTCOB_OSC_OFS, 8'hB0 | 8'(i << 2) | 8'(3 - i));
      rd(RTCOB_OSC_OFS, v);
      `CHK("osc rd", 8'hB0 | 8'(i << 2) | 8'(3 - i), v)
      `CHK("drive", (i > 1) ? RTCOB_DRV_HIGH : rtcob_drive_e'(i), CFG_O.drive)
      `CHK("cap", (i < 2) ? RTCOB_CAP_12P5 : rtcob_cap_e'(3 - i), CFG_O.load_cap)
      `CHK("h12 lj", 2'b11, {CFG_O.hour_12, CFG_O.low_jitter})
    end
    CLK_SEL_I = 1;
    STOPWATCH_MODE_I = 1;
    cy(3);
    `CHK("clk inv", 1'b0, CLK_OUT_O)
    `CHK("sw h12", 1'b0, CFG_O.hour_12)
    $display("test oscillator done");
    wr(RTCOB_BSW_OFS, 8'hFF);
    rd(RTCOB_BSW_OFS, v);
    `CHK("bsw rd", 8'h1F, v)
    BATTERY_MODE_I = 1;
    cy(4);
    `CHK("bs off", 2'b00, {BATTERY_SWITCHED_FLAG_O, CLK_OUT_OE_B_O})
    BATTERY_MODE_I = 0;
    wr(RTCOB_BSW_OFS, 8'h00);
    $display("test switch disable done");
    BS_INT_EN_I = 1;
    STAMP_OUT_EN_I = 1;
    STAMP_OUT_I = 1;
    STAMP_DIN_I = 1;
    STAMP_MECH_I = 1;
    cy(2);
    `CHK("main pins", 6'b000011, {INT_PIN_O, SDA_O, CLK_OUT_OE_B_O, STAMP_OE_B_O,
      STAMP_DIN_O, STAMP_O})
    BATTERY_MODE_I = 1;
    cy(3);
    `CHK("enter", 6'b101111, {BATTERY_SWITCHED_FLAG_O, INT_PIN_OE_B_O, CLK_OUT_OE_B_O,
      STAMP_OE_B_O, ~STAMP_DIN_O, STAMP_MECH_O})
    STAMP_MECH_I = 0;
    st();
    by({RTCOB_DEV_ADDR, 1'b0}, v, a);
    sp();
    `CHK("bat ack", 1'b1, a)
    `CHK("mech", 1'b0, STAMP_MECH_O)
    `CHK("pulse on", 1'b0, INT_PIN_OE_B_O)
    tick2();
    `CHK("pulse end", 1'b1, INT_PIN_OE_B_O)
    INT_PIN_CLK_MODE_I = 1;
    cy(2);
    `CHK("clk mode off", 1'b1, INT_PIN_OE_B_O)
    INT_PIN_BAT_IND_I = 1;
    cy(2);
    `CHK("bat ind", 1'b0, INT_PIN_OE_B_O)
    INT_PIN_BAT_IND_I = 0;
    INT_PIN_CLK_MODE_I = 0;
    BATTERY_MODE_I = 0;
    cy(3);
    `CHK("exit pulse", 1'b0, INT_PIN_OE_B_O)
    rd(RTCOB_FLAGS_OFS, v);
    `CHK("flag rd", 1'b1, v[RTCOB_BATFLG_BIT])
    wr(RTCOB_FLAGS_OFS, 8'h00);
    `CHK("flag clr", 2'b01, {BATTERY_SWITCHED_FLAG_O, INT_PIN_OE_B_O})
    $display("test pulse mode done");
    INT_LEVEL_MODE_I = 1;
    BATTERY_MODE_I = 1;
    cy(3);
    BATTERY_MODE_I = 0;
    tick2();
    `CHK("level", 1'b0, INT_PIN_OE_B_O)
    wr(RTCOB_FLAGS_OFS, 8'h00);
    cy(2);
    `CHK("level clr", 1'b1, INT_PIN_OE_B_O)
    $display("test level mode done");
    complete_run();
  end
endmodule : test_rtcob_cfg
